// file: hdl/sleg_pkg.sv
// Constants for the second link error status group and its command port.
// Assumes every user of the package shares one clock and one reset.
package sleg_pkg;

	// ************************************************************
	// Register geometry
	// ************************************************************
	localparam int REG_W = 16;
	localparam int LINK_N = 7;
	localparam int STD_N = 8;
	localparam int CODE_W = 4;

	localparam logic [REG_W-1:0] REG_RST = 16'h0000;
	// Bits 7 to 15 carry no condition or event
	localparam logic [REG_W-1:0] LINK_MASK = 16'h007f;
	// Standard event latch uses bits 0 to 7, bits 8 to 15 read zero
	localparam logic [REG_W-1:0] STD_MASK = 16'h00ff;

	// ************************************************************
	// Link error bit positions
	// ************************************************************
	localparam int BIT_REFERENCE = 0;
	localparam int BIT_SOURCE_SYNTH = 1;
	localparam int BIT_OUTPUT = 2;
	localparam int BIT_RF_IN_FIRST = 3;
	localparam int BIT_RF_IN_SECOND = 4;
	localparam int BIT_IQ_MOD = 5;
	localparam int BIT_CELL_SITE = 6;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [CODE_W-1:0] CMD_COND_QUERY = 4'h0;
	localparam logic [CODE_W-1:0] CMD_PTR_QUERY = 4'h1;
	localparam logic [CODE_W-1:0] CMD_NTR_QUERY = 4'h2;
	localparam logic [CODE_W-1:0] CMD_PTR_WRITE = 4'h3;
	localparam logic [CODE_W-1:0] CMD_NTR_WRITE = 4'h4;
	localparam logic [CODE_W-1:0] CMD_EVENT_QUERY = 4'h5;
	localparam logic [CODE_W-1:0] CMD_ENABLE_QUERY = 4'h6;
	localparam logic [CODE_W-1:0] CMD_ENABLE_WRITE = 4'h7;
	localparam logic [CODE_W-1:0] CMD_STD_EVENT_QUERY = 4'h8;

endpackage

// file: hdl/sleg_event_latch.sv
// Transition filters and sticky event register for one status group.
// Assumes the condition input is a registered value in the same clock domain.
module sleg_event_latch
	import sleg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Condition and filters
	input wire logic [REG_W-1:0] i_cond,
	input wire logic [REG_W-1:0] i_ptr,
	input wire logic [REG_W-1:0] i_ntr,
	// Clear request, one cycle
	input wire logic i_clear,
	// Event register
	output logic [REG_W-1:0] o_event
);

	// ************************************************************
	// Edge detection
	// ************************************************************
	logic [REG_W-1:0] prev_q;
	logic [REG_W-1:0] event_q;
	logic [REG_W-1:0] event_d;
	logic [REG_W-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < REG_W; g++) begin : g_bit
			// Rise through positive filter, fall through negative filter
			assign hit[g] = (i_cond[g] & ~prev_q[g] & i_ptr[g]) |
				(~i_cond[g] & prev_q[g] & i_ntr[g]);
			// A new transition wins over a clear in the same cycle
			assign event_d[g] = hit[g] | (event_q[g] & ~i_clear);
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_q <= REG_RST;
			event_q <= REG_RST;
		end else begin
			prev_q <= i_cond;
			event_q <= event_d;
		end
	end

	assign o_event = event_q;

endmodule // sleg_event_latch

// file: hdl/sleg_top.sv
// Second link error status group with its standard event latch and query port.
// Assumes the command decoder presents each status command as a one-cycle strobe
// and that the higher group enables arrive as levels from their own registers.
//
// Summary of operation
// - Check link receivers at power-up and self-test
// - Group summary drives status byte bit zero
// - Status byte needs both higher group enables
// - Bits 0-3: reference, source, output, RF first
// - Bit 4 RF second, bit 5 I/Q
// - Bit 6 cell site; bits 7, 8 reserved
// - Bits 9 to 15 carry nothing
// - Condition query returns condition register
// - Transition filters are writable and readable
// - Event register clears on query and clear-status
// - Enable register is stored and readable
// - Standard event bits 8-15 read zero
module sleg_top
	import sleg_pkg::*;
(
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// Link receiver error levels, one per board
	input wire logic [LINK_N-1:0] I_LINK_ERR,
	// Self-test query and clear-status strobes
	input wire logic I_SELF_TEST,
	input wire logic I_CLEAR_STATUS,
	// Enables in the communication and hardware groups
	input wire logic I_COMM_SMB_EN,
	input wire logic I_HW_SMB_EN,
	// Standard event pulses, bits 0 to 7
	input wire logic [STD_N-1:0] I_STD_EVENT,
	// Status command port
	input wire logic I_CMD_VALID,
	input wire logic [CODE_W-1:0] I_CMD_CODE,
	input wire logic [REG_W-1:0] I_CMD_DATA,
	// Query answer
	output logic O_RSP_VALID,
	output logic [REG_W-1:0] O_RSP_DATA,
	// Summary outputs
	output logic O_GROUP_SUMMARY,
	output logic O_STB_BIT0,
	// Check activity
	output logic O_CHECK_BUSY
);

	// ************************************************************
	// Command decoding
	// ************************************************************
	function automatic logic is_cmd(input logic valid, input logic [CODE_W-1:0] code,
		input logic [CODE_W-1:0] want);
		is_cmd = valid & (code == want);
	endfunction

	function automatic logic is_query(input logic [CODE_W-1:0] code);
		is_query = (code == CMD_COND_QUERY) | (code == CMD_PTR_QUERY) |
			(code == CMD_NTR_QUERY) | (code == CMD_EVENT_QUERY) |
			(code == CMD_ENABLE_QUERY) | (code == CMD_STD_EVENT_QUERY);
	endfunction

	wire ptr_wr = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_PTR_WRITE);
	wire ntr_wr = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_NTR_WRITE);
	wire enable_wr = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_ENABLE_WRITE);
	wire event_rd = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_EVENT_QUERY);
	wire std_rd = is_cmd(I_CMD_VALID, I_CMD_CODE, CMD_STD_EVENT_QUERY);
	wire any_query = I_CMD_VALID & is_query(I_CMD_CODE);

	// ************************************************************
	// Link check sequencing
	// ************************************************************
	// The first cycle after reset release stands for the power-up check
	logic power_up_q;
	logic check_q;
	wire check_now = power_up_q | I_SELF_TEST;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			power_up_q <= 1'b1;
			check_q <= 1'b0;
		end else begin
			power_up_q <= 1'b0;
			check_q <= check_now;
		end
	end

	// ************************************************************
	// Condition register
	// ************************************************************
	// Errors are sampled only at a check, so a receiver glitch between
	// checks is not reported; that matches a query-driven self-test.
	logic [REG_W-1:0] cond_q;
	logic [REG_W-1:0] cond_d;
	logic [REG_W-1:0] cond_sample;

	always_comb begin
		cond_sample = REG_RST;
		cond_sample[BIT_REFERENCE] = I_LINK_ERR[BIT_REFERENCE];
		cond_sample[BIT_SOURCE_SYNTH] = I_LINK_ERR[BIT_SOURCE_SYNTH];
		cond_sample[BIT_OUTPUT] = I_LINK_ERR[BIT_OUTPUT];
		cond_sample[BIT_RF_IN_FIRST] = I_LINK_ERR[BIT_RF_IN_FIRST];
		cond_sample[BIT_RF_IN_SECOND] = I_LINK_ERR[BIT_RF_IN_SECOND];
		cond_sample[BIT_IQ_MOD] = I_LINK_ERR[BIT_IQ_MOD];
		cond_sample[BIT_CELL_SITE] = I_LINK_ERR[BIT_CELL_SITE];
	end

	// Reserved and unused bits are forced to zero
	assign cond_d = check_now ? (cond_sample & LINK_MASK) : cond_q;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cond_q <= REG_RST;
		end else begin
			cond_q <= cond_d;
		end
	end

	// ************************************************************
	// Filter and enable registers
	// ************************************************************
	logic [REG_W-1:0] ptr_q;
	logic [REG_W-1:0] ntr_q;
	logic [REG_W-1:0] enable_q;
	wire [REG_W-1:0] ptr_d = ptr_wr ? I_CMD_DATA : ptr_q;
	wire [REG_W-1:0] ntr_d = ntr_wr ? I_CMD_DATA : ntr_q;
	// Writing zero or a reset is the only way to clear the mask
	wire [REG_W-1:0] enable_d = enable_wr ? I_CMD_DATA : enable_q;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ptr_q <= REG_RST;
			ntr_q <= REG_RST;
			enable_q <= REG_RST;
		end else begin
			ptr_q <= ptr_d;
			ntr_q <= ntr_d;
			enable_q <= enable_d;
		end
	end

	// ************************************************************
	// Event register
	// ************************************************************
	logic [REG_W-1:0] event_val;
	wire event_clear = event_rd | I_CLEAR_STATUS;

	sleg_event_latch u_event (
		.i_clk(I_REF_CLK),
		.i_nrst(I_NRST),
		.i_cond(cond_q),
		.i_ptr(ptr_q),
		.i_ntr(ntr_q),
		.i_clear(event_clear),
		.o_event(event_val)
	);

	// ************************************************************
	// Standard event latch
	// ************************************************************
	logic [REG_W-1:0] std_q;
	logic [REG_W-1:0] std_set;
	wire std_clear = std_rd | I_CLEAR_STATUS;

	assign std_set = {{(REG_W-STD_N){1'b0}}, I_STD_EVENT};
	// A pulse in the clearing cycle survives; upper bits stay zero
	wire [REG_W-1:0] std_d = (std_set | (std_q & {REG_W{~std_clear}})) & STD_MASK;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			std_q <= REG_RST;
		end else begin
			std_q <= std_d;
		end
	end

	// ************************************************************
	// Summary path
	// ************************************************************
	wire group_summary = |(event_val & enable_q);
	// Both higher stages must pass the summary up to the status byte
	wire stb_bit0 = group_summary & I_COMM_SMB_EN & I_HW_SMB_EN;
	logic summary_q;
	logic stb_q;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			summary_q <= 1'b0;
			stb_q <= 1'b0;
		end else begin
			summary_q <= group_summary;
			stb_q <= stb_bit0;
		end
	end

	// ************************************************************
	// Query answers
	// ************************************************************
	// Event query returns the value before its own clear takes effect
	logic [REG_W-1:0] rsp_sel;
	logic rsp_valid_q;
	logic [REG_W-1:0] rsp_data_q;

	always_comb begin
		rsp_sel = REG_RST;
		unique case (I_CMD_CODE)
			CMD_COND_QUERY: rsp_sel = cond_q;
			CMD_PTR_QUERY: rsp_sel = ptr_q;
			CMD_NTR_QUERY: rsp_sel = ntr_q;
			CMD_EVENT_QUERY: rsp_sel = event_val;
			CMD_ENABLE_QUERY: rsp_sel = enable_q;
			CMD_STD_EVENT_QUERY: rsp_sel = std_q;
			default: rsp_sel = REG_RST;
		endcase
	end

	wire [REG_W-1:0] rsp_data_d = any_query ? rsp_sel : rsp_data_q;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= REG_RST;
		end else begin
			rsp_valid_q <= any_query;
			rsp_data_q <= rsp_data_d;
		end
	end

	assign O_RSP_VALID = rsp_valid_q;
	assign O_RSP_DATA = rsp_data_q;
	assign O_GROUP_SUMMARY = summary_q;
	assign O_STB_BIT0 = stb_q;
	assign O_CHECK_BUSY = check_q;

endmodule // sleg_top

// file: verification/sleg_checker.sv
// Port checker for the second link error group.
// Assumes it is bound to sleg_top, one clock domain.
module sleg_checker
	import sleg_pkg::*;
(
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// Watched inputs
	input wire logic I_SELF_TEST,
	input wire logic I_COMM_SMB_EN,
	input wire logic I_HW_SMB_EN,
	input wire logic I_CMD_VALID,
	input wire logic [CODE_W-1:0] I_CMD_CODE,
	// Watched outputs
	input wire logic O_RSP_VALID,
	input wire logic [REG_W-1:0] O_RSP_DATA,
	input wire logic O_STB_BIT0,
	input wire logic O_CHECK_BUSY
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	wire logic is_wr = I_CMD_CODE inside {CMD_PTR_WRITE, CMD_NTR_WRITE, CMD_ENABLE_WRITE};
	wire logic is_q = I_CMD_VALID && I_CMD_CODE <= CMD_STD_EVENT_QUERY && !is_wr;
	sequence s_link_q;
		I_CMD_VALID && (I_CMD_CODE == CMD_COND_QUERY || I_CMD_CODE == CMD_EVENT_QUERY);
	endsequence
	sequence s_std_q;
		I_CMD_VALID && I_CMD_CODE == CMD_STD_EVENT_QUERY;
	endsequence
	a_query_answer: assert property (is_q |=> O_RSP_VALID)
		else $error("query without answer");
	a_write_silent: assert property (!is_q |=> !O_RSP_VALID)
		else $error("answer without query");
	a_data_holds: assert property (!O_RSP_VALID |-> $stable(O_RSP_DATA))
		else $error("answer data moved");
	a_link_unused: assert property (s_link_q ##1 1'b1 |-> O_RSP_DATA[15:7] == 9'h000)
		else $error("unused link bits set");
	a_std_reserved: assert property (s_std_q |=> O_RSP_DATA[15:8] == 8'h00)
		else $error("reserved standard bits set");
	a_stb_gate: assert property (O_STB_BIT0 |-> $past(I_COMM_SMB_EN && I_HW_SMB_EN))
		else $error("status bit without enables");
	a_stb_drop: assert property (!I_HW_SMB_EN |=> !O_STB_BIT0)
		else $error("status bit with group disabled");
	a_busy_start: assert property (I_SELF_TEST |=> O_CHECK_BUSY)
		else $error("self-test started no check");
	a_busy_once: assert property (O_CHECK_BUSY && !I_SELF_TEST |=> !O_CHECK_BUSY)
		else $error("check busy too long");
endmodule // sleg_checker

// file: verification/sleg_ctrl_model.sv
// Remote controller model driving the status command port.
// Assumes the device takes a command at the rising edge after set-up.
module sleg_ctrl_model
	import sleg_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Command port
	output logic o_valid,
	output logic [CODE_W-1:0] o_code,
	output logic [REG_W-1:0] o_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_valid = 1'b0;
		o_code = 4'h0;
		o_data = 16'h0000;
	end
	// Idle cycle between commands, so the strobe never changes twice in one step
	task automatic cmd(input logic [CODE_W-1:0] code, input logic [REG_W-1:0] data);
		@(negedge i_clk);
		o_valid = 1'b1;
		o_code = code;
		o_data = data;
		@(negedge i_clk);
		o_valid = 1'b0;
		o_data = ~data;
	endtask
	// No clear command exists for the enable mask
	task automatic clear_enable();
		cmd(CMD_ENABLE_WRITE, 16'h0000);
	endtask
endmodule // sleg_ctrl_model

// file: verification/testbench.sv
// Self-checking bench for the second link error group.
// Assumes the controller model and checker compile first.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import sleg_pkg::*;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clk, nrst, self_test, clr, comm_en, hw_en;
	logic [LINK_N-1:0] link;
	logic [STD_N-1:0] stde;
	logic cmd_v, rsp_v, summ, stb, busy;
	logic [CODE_W-1:0] code;
	logic [REG_W-1:0] data, rsp_d;
	int num_errors = 0;
	int checked = 0;
	sleg_ctrl_model ctrl (.i_clk(clk), .o_valid(cmd_v), .o_code(code), .o_data(data));
	sleg_top DUT (.I_REF_CLK(clk), .I_NRST(nrst), .I_LINK_ERR(link), .I_SELF_TEST(self_test),
		.I_CLEAR_STATUS(clr), .I_COMM_SMB_EN(comm_en), .I_HW_SMB_EN(hw_en), .I_STD_EVENT(stde),
		.I_CMD_VALID(cmd_v), .I_CMD_CODE(code), .I_CMD_DATA(data), .O_RSP_VALID(rsp_v),
		.O_RSP_DATA(rsp_d), .O_GROUP_SUMMARY(summ), .O_STB_BIT0(stb), .O_CHECK_BUSY(busy));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic q(input logic [CODE_W-1:0] c, input logic [REG_W-1:0] exp);
		ctrl.cmd(c, 16'h0000);
		chk({15'h0000, rsp_v}, 16'h0001);
		chk(rsp_d, exp);
	endtask
	// Waits long enough for event, summary and status byte to settle
	task automatic run_check(input logic [LINK_N-1:0] v);
		@(negedge clk);
		link = v;
		self_test = 1'b1;
		@(negedge clk);
		self_test = 1'b0;
		chk({15'h0000, busy}, 16'h0001);
		repeat (3) @(negedge clk);
	endtask
	task automatic pulse_clear();
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
	endtask
	task automatic end_sim();
		$display("checked %0d, num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reg_rw();
		q(CMD_PTR_QUERY, REG_RST);
		q(CMD_ENABLE_QUERY, REG_RST);
		ctrl.cmd(CMD_PTR_WRITE, 16'ha55a);
		ctrl.cmd(CMD_NTR_WRITE, 16'h5aa5);
		ctrl.cmd(CMD_ENABLE_WRITE, 16'hffff);
		q(CMD_PTR_QUERY, 16'ha55a);
		q(CMD_NTR_QUERY, 16'h5aa5);
		q(CMD_ENABLE_QUERY, 16'hffff);
	endtask
	task automatic t_bits();
		for (int i = 0; i < LINK_N; i++) begin
			run_check(7'h01 << i);
			q(CMD_COND_QUERY, 16'h0001 << i);
		end
		run_check(7'h7f);
		q(CMD_COND_QUERY, LINK_MASK);
	endtask
	task automatic t_events();
		ctrl.cmd(CMD_PTR_WRITE, 16'h0001);
		ctrl.cmd(CMD_NTR_WRITE, 16'h0002);
		ctrl.cmd(CMD_ENABLE_WRITE, 16'h0003);
		run_check(7'h00);
		pulse_clear();
		q(CMD_EVENT_QUERY, 16'h0000);
		comm_en = 1'b1;
		hw_en = 1'b1;
		run_check(7'h03);
		chk({15'h0000, summ}, 16'h0001);
		chk({15'h0000, stb}, 16'h0001);
		q(CMD_EVENT_QUERY, 16'h0001);
		q(CMD_EVENT_QUERY, 16'h0000);
		hw_en = 1'b0;
		run_check(7'h00);
		chk({15'h0000, summ}, 16'h0001);
		chk({15'h0000, stb}, 16'h0000);
		ctrl.clear_enable();
		repeat (2) @(negedge clk);
		chk({15'h0000, summ}, 16'h0000);
		q(CMD_EVENT_QUERY, 16'h0002);
	endtask
	task automatic t_std();
		@(negedge clk);
		stde = 8'hff;
		@(negedge clk);
		stde = 8'h81;
		@(negedge clk);
		stde = 8'h00;
		q(CMD_STD_EVENT_QUERY, STD_MASK);
		q(CMD_STD_EVENT_QUERY, 16'h0000);
	endtask
	// Unknown codes get no answer and leave the last answer in place
	task automatic t_misc();
		q(CMD_PTR_QUERY, 16'h0001);
		ctrl.cmd(4'hf, 16'h1234);
		chk({15'h0000, rsp_v}, 16'h0000);
		chk(rsp_d, 16'h0001);
		@(negedge clk);
		stde = 8'h04;
		@(negedge clk);
		stde = 8'h00;
		pulse_clear();
		q(CMD_STD_EVENT_QUERY, 16'h0000);
		@(negedge clk);
		stde = 8'h10;
		clr = 1'b1;
		@(negedge clk);
		stde = 8'h00;
		clr = 1'b0;
		q(CMD_STD_EVENT_QUERY, 16'h0010);
	endtask
	// A reset in mid-run repeats the power-up check and clears the enable
	task automatic t_reset();
		ctrl.cmd(CMD_ENABLE_WRITE, 16'h00ff);
		@(negedge clk);
		nrst = 1'b0;
		link = 7'h2a;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		q(CMD_COND_QUERY, 16'h002a);
		q(CMD_ENABLE_QUERY, REG_RST);
		q(CMD_PTR_QUERY, REG_RST);
	endtask
	initial begin
		{nrst, self_test, clr, comm_en, hw_en, stde} = '0;
		link = 7'h55;
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		q(CMD_COND_QUERY, 16'h0055);
		t_reg_rw();
		t_bits();
		t_events();
		t_std();
		t_misc();
		t_reset();
		end_sim();
	end
endmodule // testbench

bind sleg_top sleg_checker chk_i (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
	.I_SELF_TEST(I_SELF_TEST), .I_COMM_SMB_EN(I_COMM_SMB_EN), .I_HW_SMB_EN(I_HW_SMB_EN),
	.I_CMD_VALID(I_CMD_VALID), .I_CMD_CODE(I_CMD_CODE), .O_RSP_VALID(O_RSP_VALID),
	.O_RSP_DATA(O_RSP_DATA), .O_STB_BIT0(O_STB_BIT0), .O_CHECK_BUSY(O_CHECK_BUSY));
